// file: cms_clock_ctrl.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module cms_clock_ctrl (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire cms_pkg::cms_reg_req_t      reg_req,
   output logic [cms_pkg::DATA_W-1:0]      reg_rdata,
   input  wire logic                       onchip_osc_tick,
   input  wire logic                       ext_osc_tick,
   input  wire logic                       vco_base_tick,
   output cms_pkg::cms_clk_en_t            clk_en,
   output logic                            clock_output_pin,
   output logic                            osc_enable,
   output logic                            pll_enable,
   output logic                            osc_source_sel
);
   import cms_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic                 osc_disconnect_sel;
      logic                 vco_bypass_sel;
      logic                 output_toggle_enable;
      logic [SLOW_W-1:0]    slowdown_divider_field;
      logic [FB_W-1:0]      feedback_divider_sel;
      cms_pwr_t             pwr;
      logic                 ext_sel;
      logic [1:0]           out_src;
      cms_clk_mode_t        clk_mode;
      logic [CRED_W-1:0]    credit;
      cms_clk_en_t          en;
      logic                 clk_out;
      logic                 osc_en;
      logic                 pll_en;
      logic [DATA_W-1:0]    rdata;
   } cms_state_t;

   cms_state_t          st_reg;
   cms_state_t          st_next;
   cms_clk_mode_t       cfg_mode;
   logic                osc_live;
   logic                vco_live;
   logic [CRED_W-1:0]   add_amt;
   logic [CRED_W-1:0]   div_amt;
   logic [CRED_W:0]     sum;
   logic                sel_tick;
   logic                mod_tick;
   logic                slow_tick;
   logic [DIV_W-1:0]    slow_div;

   // ==========================================================
   // Rate dividers
   // Fixed one third of the system tick gives the 25 MHz group
   cms_tick_div u_module_div (
      .core_clk (core_clk),
      .rst      (rst),
      .tick_in  (st_reg.en.sys),
      .divisor  (MODULE_DIV),
      .tick_out (mod_tick)
   );

   // Slow-down factor is field plus one, so zero still runs
   assign slow_div = (st_reg.pwr == PM_SLOW) ?
                     DIV_W'({1'b0, st_reg.slowdown_divider_field} + 5'd1) : RST_DIV;

   cms_tick_div u_slow_div (
      .core_clk (core_clk),
      .rst      (rst),
      .tick_in  (mod_tick),
      .divisor  (slow_div),
      .tick_out (slow_tick)
   );

   // ==========================================================
   // Next state
   always_comb begin
      st_next  = st_reg;
      cfg_mode = cms_decode_mode(st_reg.osc_disconnect_sel, st_reg.vco_bypass_sel);
      // Source ticks die once power-down drops the enables
      osc_live = (st_reg.ext_sel ? ext_osc_tick : onchip_osc_tick) & st_reg.osc_en;
      vco_live = vco_base_tick & st_reg.pll_en;
      add_amt  = '0;
      div_amt  = PK_FACTOR;
      sum      = '0;

      // Register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            OFS_MODE_CTRL: begin
               st_next.osc_disconnect_sel     = reg_req.wdata[MC_DISC_BIT];
               st_next.vco_bypass_sel         = reg_req.wdata[MC_BYP_BIT];
               st_next.output_toggle_enable   = reg_req.wdata[MC_TOG_BIT];
               st_next.slowdown_divider_field = reg_req.wdata[MC_SLOW_LSB +: SLOW_W];
            end
            OFS_FB_DIV:  st_next.feedback_divider_sel = reg_req.wdata[FB_W-1:0];
            OFS_PWR: begin
               st_next.pwr     = cms_pwr_t'(reg_req.wdata[1:0]);
               st_next.ext_sel = reg_req.wdata[PM_EXT_BIT];
            end
            OFS_CLK_OUT: st_next.out_src = reg_req.wdata[1:0];
            default: ;
         endcase
      end

      // Read data stand for one cycle only; unmapped reads give zero
      st_next.rdata = '0;
      if (reg_req.rd) begin
         case (reg_req.addr)
            OFS_MODE_CTRL: st_next.rdata = {st_reg.slowdown_divider_field, 1'b0,
                                            st_reg.output_toggle_enable,
                                            st_reg.vco_bypass_sel, st_reg.osc_disconnect_sel};
            OFS_FB_DIV:    st_next.rdata = {2'b00, st_reg.feedback_divider_sel};
            OFS_PWR:       st_next.rdata = {5'b0_0000, st_reg.ext_sel, st_reg.pwr};
            OFS_CLK_OUT:   st_next.rdata = {6'b00_0000, st_reg.out_src};
            OFS_STATUS:    st_next.rdata = {2'b00, st_reg.pll_en, st_reg.osc_en,
                                            st_reg.pwr, st_reg.clk_mode};
            default:       st_next.rdata = '0;
         endcase
      end

      // System tick: credit builds on source ticks and pays out one tick per divisor
      case (st_reg.clk_mode)
         CM_PLL: begin
            add_amt = (osc_live && st_reg.pll_en) ?
                      {2'b00, st_reg.feedback_divider_sel} : '0;
         end
         CM_PRESCALE: begin
            add_amt = osc_live ? 8'h01 : 8'h00;
         end
         CM_BASE: begin
            add_amt = vco_live ? 8'h01 : 8'h00;
            div_amt = K_FACTOR;
         end
         default: add_amt = '0;
      endcase

      if (cfg_mode != st_reg.clk_mode) begin
         // Restart cleanly in the new mode instead of carrying old credit
         st_next.clk_mode = cfg_mode;
         st_next.credit   = '0;
         st_next.en.sys   = 1'b0;
      end else begin
         st_next.en.sys = (st_reg.credit >= div_amt);
         sum = {1'b0, st_reg.credit} + {1'b0, add_amt} -
               (st_next.en.sys ? {1'b0, div_amt} : 9'h000);
         // Saturate so a source far above the core rate cannot wrap
         st_next.credit = sum[CRED_W] ? CREDIT_MAX : sum[CRED_W-1:0];
      end

      // Derived clock enables
      st_next.en.flash_fast = st_reg.en.sys;
      st_next.en.flash_if   = mod_tick;
      st_next.en.periph     = slow_tick && (st_reg.pwr != PM_PDOWN);
      st_next.en.capture    = slow_tick && (st_reg.pwr != PM_PDOWN);
      st_next.en.cpu        = slow_tick && (st_reg.pwr != PM_IDLE)
                              && (st_reg.pwr != PM_PDOWN);

      // Power-down stops both sources
      st_next.osc_en = (st_reg.pwr != PM_PDOWN);
      st_next.pll_en = (st_reg.pwr != PM_PDOWN);

      // Clock output source and optional halving
      case (st_reg.out_src)
         2'd0:    sel_tick = st_reg.en.sys;
         2'd1:    sel_tick = mod_tick;
         2'd2:    sel_tick = slow_tick;
         default: sel_tick = osc_live;
      endcase
      if (st_reg.output_toggle_enable) begin
         st_next.clk_out = st_reg.clk_out ^ sel_tick;
      end else begin
         st_next.clk_out = sel_tick;
      end
   end

   // ==========================================================
   // State register; reset lands in active mode on the on-chip source
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '{osc_disconnect_sel:     RST_MODE_CTRL[MC_DISC_BIT],
                     vco_bypass_sel:         RST_MODE_CTRL[MC_BYP_BIT],
                     output_toggle_enable:   RST_MODE_CTRL[MC_TOG_BIT],
                     slowdown_divider_field: RST_MODE_CTRL[MC_SLOW_LSB +: SLOW_W],
                     feedback_divider_sel:   RST_FB_DIV,
                     pwr:                    PM_ACTIVE,
                     ext_sel:                1'b0,
                     out_src:                RST_CLK_OUT,
                     clk_mode:               CM_PLL,
                     credit:                 '0,
                     en:                     '0,
                     clk_out:                1'b0,
                     osc_en:                 1'b1,
                     pll_en:                 1'b1,
                     rdata:                  '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign reg_rdata        = st_reg.rdata;
   assign clk_en           = st_reg.en;
   assign clock_output_pin = st_reg.clk_out;
   assign osc_enable       = st_reg.osc_en;
   assign pll_enable       = st_reg.pll_en;
   assign osc_source_sel   = st_reg.ext_sel;

   // ==========================================================
   // Checks
   mode_switch_clean_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_mode != st_reg.clk_mode) |=>
         (st_reg.clk_mode == $past(cfg_mode)) && !st_reg.en.sys && (st_reg.credit == '0))
      else $error("mode switch not applied cleanly");

   sys_tick_paid_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.en.sys && ($past(cfg_mode) == $past(st_reg.clk_mode))) |->
         ($past(st_reg.credit) >= K_FACTOR))
      else $error("system tick without enough credit");

   pll_gain_n_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.clk_mode == CM_PLL && cfg_mode == CM_PLL && osc_live && st_reg.pll_en
       && st_reg.credit < PK_FACTOR) |=>
         (st_reg.credit == CRED_W'($past(st_reg.credit) + {2'b00, $past(st_reg.feedback_divider_sel)})))
      else $error("PLL credit did not grow by N");

   base_needs_vco_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.clk_mode == CM_BASE && cfg_mode == CM_BASE && !vco_base_tick
       && st_reg.credit < K_FACTOR) |=>
         !st_reg.en.sys && (st_reg.credit == $past(st_reg.credit)))
      else $error("base mode ticked with no VCO base tick");

   flash_fast_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      st_reg.en.flash_fast == $past(st_reg.en.sys))
      else $error("flash fast clock does not follow system tick");

   idle_cpu_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.pwr == PM_IDLE) [*2] |-> !clk_en.cpu && (clk_en.periph == $past(slow_tick)))
      else $error("CPU clock running in idle");

   pdown_sources_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.pwr == PM_PDOWN) |=> !osc_enable && !pll_enable)
      else $error("sources still on in power-down");

   toggle_halves_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.output_toggle_enable && sel_tick) |=> (clock_output_pin != $past(clock_output_pin)))
      else $error("clock output did not toggle");

   reset_active_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(rst) |-> (st_reg.pwr == PM_ACTIVE) && !osc_source_sel && osc_enable && pll_enable)
      else $error("not active on on-chip source after reset");

   // ==========================================================
   // Checks on software control and slowed clocks
   // Nothing but a write may move the power mode or the source
   pwr_by_write_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.pwr != $past(st_reg.pwr)) |-> ($past(reg_req.wr) && ($past(reg_req.addr) == OFS_PWR)))
      else $error("power mode changed without a write");

   src_by_write_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.ext_sel != $past(st_reg.ext_sel)) |-> ($past(reg_req.wr) && ($past(reg_req.addr) == OFS_PWR)))
      else $error("oscillator source changed without a write");

   fb_write_lands_a: assert property (@(posedge core_clk) disable iff (rst)
      (reg_req.wr && (reg_req.addr == OFS_FB_DIV)) |=>
         (st_reg.feedback_divider_sel == $past(reg_req.wdata[FB_W-1:0])))
      else $error("feedback divider write lost");

   prescale_step_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.clk_mode == CM_PRESCALE && cfg_mode == CM_PRESCALE && osc_live
       && st_reg.credit < PK_FACTOR) |=>
         (st_reg.credit == CRED_W'($past(st_reg.credit) + 8'h01)))
      else $error("prescaler credit did not grow by one");

   // One divider feeds all three, so a factor change cannot split them
   slow_common_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.pwr == PM_SLOW) |=>
         (clk_en.cpu == $past(slow_tick)) && (clk_en.periph == $past(slow_tick))
         && (clk_en.capture == $past(slow_tick)))
      else $error("slow-down clocks not on one common divider");

   pdown_no_tick_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.pwr == PM_PDOWN && !osc_enable && !pll_enable && (cfg_mode == st_reg.clk_mode)
       && st_reg.credit < PK_FACTOR) |=>
         !st_reg.en.sys && (st_reg.credit == $past(st_reg.credit)))
      else $error("system tick in power-down");

endmodule : cms_clock_ctrl

// file: cms_osc_model.sv
`timescale 1ns/1ps
module cms_osc_model #(
   parameter int ONCHIP_PER = 20,
   parameter int EXT_PER    = 30,
   parameter int VCO_PER    = 6
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic osc_enable,
   output logic      onchip_osc_tick,
   output logic      ext_osc_tick,
   output logic      vco_base_tick
);
   int on_cnt;
   int ex_cnt;
   int vc_cnt;

   // =========================================
   // Tick sources
   // A switched-off oscillator gives no edges, so both oscillator ticks stop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         on_cnt          <= 0;
         ex_cnt          <= 0;
         vc_cnt          <= 0;
         onchip_osc_tick <= 1'b0;
         ext_osc_tick    <= 1'b0;
         vco_base_tick   <= 1'b0;
      end else begin
         on_cnt          <= (on_cnt >= ONCHIP_PER - 1) ? 0 : on_cnt + 1;
         ex_cnt          <= (ex_cnt >= EXT_PER - 1) ? 0 : ex_cnt + 1;
         vc_cnt          <= (vc_cnt >= VCO_PER - 1) ? 0 : vc_cnt + 1;
         onchip_osc_tick <= osc_enable && (on_cnt == 0);
         ext_osc_tick    <= osc_enable && (ex_cnt == 0);
         vco_base_tick   <= (vc_cnt == 0); // VCO runs free of the oscillator
      end
   end
endmodule : cms_osc_model

// file: cms_pkg.sv
package cms_pkg;

   // ==========================================================
   // Register port geometry
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FB_W   = 6;
   localparam int unsigned SLOW_W = 4;
   localparam int unsigned DIV_W  = 5;
   localparam int unsigned CRED_W = 8;

   // ==========================================================
   // Register offsets
   localparam logic [2:0] OFS_MODE_CTRL = 3'h0;
   localparam logic [2:0] OFS_FB_DIV    = 3'h1;
   localparam logic [2:0] OFS_PWR       = 3'h2;
   localparam logic [2:0] OFS_CLK_OUT   = 3'h3;
   localparam logic [2:0] OFS_STATUS    = 3'h4;

   // ==========================================================
   // Field positions
   localparam int unsigned MC_DISC_BIT = 0;
   localparam int unsigned MC_BYP_BIT  = 1;
   localparam int unsigned MC_TOG_BIT  = 2;
   localparam int unsigned MC_SLOW_LSB = 4;
   localparam int unsigned PM_EXT_BIT  = 2;

   // ==========================================================
   // Values after reset
   localparam logic [7:0]        RST_MODE_CTRL = 8'h00;
   localparam logic [FB_W-1:0]   RST_FB_DIV    = 6'h0F;
   localparam logic [1:0]        RST_CLK_OUT   = 2'h0;
   localparam logic [DIV_W-1:0]  RST_DIV       = 5'h01;

   // ==========================================================
   // Fixed dividers and clock ratios
   localparam logic [CRED_W-1:0] P_FACTOR      = 8'h01;
   localparam logic [CRED_W-1:0] K_FACTOR      = 8'h02;
   localparam logic [CRED_W-1:0] PK_FACTOR     = CRED_W'(P_FACTOR * K_FACTOR);
   localparam int unsigned       FAST_MHZ      = 75;
   localparam int unsigned       MODULE_MHZ    = 25;
   localparam logic [DIV_W-1:0]  MODULE_DIV    = DIV_W'(FAST_MHZ / MODULE_MHZ);
   localparam logic [CRED_W-1:0] CREDIT_MAX    = 8'hFF;

   // ==========================================================
   // Enumerations
   typedef enum logic [1:0] {CM_PLL, CM_PRESCALE, CM_BASE} cms_clk_mode_t;
   typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_SLOW, PM_PDOWN} cms_pwr_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } cms_reg_req_t;

   typedef struct packed {
      logic sys;
      logic cpu;
      logic periph;
      logic capture;
      logic flash_fast;
      logic flash_if;
   } cms_clk_en_t;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic [DIV_W-1:0] div_cur;
      logic             out;
   } cms_div_state_t;

   // Two select bits to the working mode; disconnect wins over bypass
   function automatic cms_clk_mode_t cms_decode_mode(input logic disc, input logic byp);
      if (disc) begin
         return CM_BASE;
      end
      return byp ? CM_PRESCALE : CM_PLL;
   endfunction : cms_decode_mode

endpackage : cms_pkg

// file: cms_tick_div.sv
`timescale 1ns/1ps
module cms_tick_div (
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic                      tick_in,
   input  wire logic [cms_pkg::DIV_W-1:0] divisor,
   output logic                           tick_out
);
   import cms_pkg::*;

   cms_div_state_t s_reg;
   cms_div_state_t s_next;

   // ==========================================================
   // Divider: a new divisor is taken only at a period boundary,
   // so a change never shortens the period in flight
   always_comb begin
      s_next     = s_reg;
      s_next.out = 1'b0;
      if (tick_in) begin
         if ((s_reg.cnt + 5'd1) >= s_reg.div_cur) begin
            s_next.cnt     = '0;
            s_next.out     = 1'b1;
            s_next.div_cur = divisor;
         end else begin
            s_next.cnt = s_reg.cnt + 5'd1;
         end
      end else if (s_reg.cnt == '0) begin
         s_next.div_cur = divisor;
      end
   end

   // State register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '{cnt: '0, div_cur: RST_DIV, out: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick_out = s_reg.out;

   // ==========================================================
   // Checks
   out_has_cause_a: assert property (@(posedge core_clk) disable iff (rst)
      tick_out |-> $past(tick_in))
      else $error("divided tick without an input tick");

   div_one_pass_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_in && s_reg.div_cur == 5'd1) |=> tick_out)
      else $error("divide by one dropped a tick");

endmodule : cms_tick_div

// file: tb.sv
`timescale 1ns/1ps
module tb;
   import cms_pkg::*;
   localparam int W = 600;
   logic                 core_clk;
   logic                 rst;
   cms_reg_req_t         reg_req;
   logic [DATA_W-1:0]    reg_rdata;
   logic                 onchip_osc_tick;
   logic                 ext_osc_tick;
   logic                 vco_base_tick;
   cms_clk_en_t          clk_en;
   logic                 clock_output_pin;
   logic                 osc_enable;
   logic                 pll_enable;
   logic                 osc_source_sel;
   logic [6:0]           taps;
   logic [7:0]           d;
   int                   errors;
   int                   tests_run;
   int                   cycles;
   int                   cnt [7];

   // Tap order: pin, sys, cpu, periph, capture, flash_fast, flash_if
   assign taps = {clock_output_pin, clk_en};

   cms_clock_ctrl u_dut (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .onchip_osc_tick(onchip_osc_tick), .ext_osc_tick(ext_osc_tick), .vco_base_tick(vco_base_tick),
      .clk_en(clk_en), .clock_output_pin(clock_output_pin), .osc_enable(osc_enable),
      .pll_enable(pll_enable), .osc_source_sel(osc_source_sel));

   cms_osc_model u_osc (.core_clk(core_clk), .rst(rst), .osc_enable(osc_enable),
      .onchip_osc_tick(onchip_osc_tick), .ext_osc_tick(ext_osc_tick), .vco_base_tick(vco_base_tick));

   // =========================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Whole run is just under 8k cycles; the ceiling leaves generous margin
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         summarize();
      end
   end

   // =========================================
   // Bus and check tasks
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_req.wr    <= 1'b1;
      reg_req.addr  <= a;
      reg_req.wdata <= v;
      @(posedge core_clk);
      reg_req.wr    <= 1'b0;
   endtask : wr_reg

   // Read data stands only in the cycle after the strobe, so sample right there
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_req.rd   <= 1'b1;
      reg_req.addr <= a;
      @(posedge core_clk);
      reg_req.rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd_reg

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic rd_check(input logic [2:0] a, input logic [7:0] exp);
      rd_reg(a, d);
      check(d, exp);
   endtask : rd_check

   // Registered outputs lag a write by up to two edges; look off the edge
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle

   // Window start phase is arbitrary, hence a tolerance on pulse counts
   task automatic check_cnt(input int b, input int e, input int tol);
      int seen;
      seen = cnt[b];
      if (seen >= e - tol && seen <= e + tol) begin
         seen = e;
      end
      check(16'(seen), 16'(e));
   endtask : check_cnt

   task automatic meas(input int n);
      foreach (cnt[i]) cnt[i] = 0;
      repeat (20) @(posedge core_clk);
      repeat (n) begin
         @(posedge core_clk);
         #1;
         for (int i = 0; i < 7; i++) cnt[i] += taps[i];
      end
   endtask : meas

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // =========================================
   // Main sequence; on-chip tick every 20, external every 30, VCO every 6
   initial begin
      rst = 1'b1;
      reg_req = '0;
      errors = 0;
      tests_run = 0;
      cycles = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd_check(OFS_MODE_CTRL, 8'h00);
      rd_check(OFS_FB_DIV, 8'h0F);
      rd_check(OFS_STATUS, 8'h30);
      rd_check(3'h5, 8'h00);
      check({osc_source_sel, osc_enable, pll_enable}, 8'h03);
      meas(W);
      check_cnt(5, 225, 2);
      check_cnt(1, 225, 2);
      check_cnt(0, 75, 2);
      check_cnt(4, 75, 2);
      wr_reg(OFS_FB_DIV, 8'h1E);
      rd_check(OFS_FB_DIV, 8'h1E);
      meas(W);
      check_cnt(5, 450, 3);
      wr_reg(OFS_FB_DIV, 8'h0F);
      wr_reg(OFS_STATUS, 8'hFF);
      rd_check(OFS_STATUS, 8'h30);
      wr_reg(OFS_MODE_CTRL, 8'h02);
      rd_check(OFS_STATUS, 8'h31);
      meas(W);
      check_cnt(5, 15, 1);
      // Base mode for both bypass settings
      for (int b = 1; b < 4; b += 2) begin
         wr_reg(OFS_MODE_CTRL, 8'(b));
         rd_check(OFS_STATUS, 8'h32);
         meas(W);
         check_cnt(5, 50, 2);
      end
      wr_reg(OFS_MODE_CTRL, 8'h02);
      wr_reg(OFS_PWR, 8'h04);
      settle();
      check(osc_source_sel, 1'b1);
      meas(W);
      check_cnt(5, 10, 1);
      wr_reg(OFS_PWR, 8'h00);
      wr_reg(OFS_MODE_CTRL, 8'h00);
      wr_reg(OFS_PWR, 8'h01);
      rd_check(OFS_STATUS, 8'h34);
      meas(W);
      check_cnt(4, 0, 0);
      check_cnt(3, 75, 2);
      check_cnt(5, 225, 2);
      wr_reg(OFS_MODE_CTRL, 8'h30);
      wr_reg(OFS_PWR, 8'h02);
      rd_check(OFS_MODE_CTRL, 8'h30);
      meas(W);
      check_cnt(3, 19, 2);
      check_cnt(2, 19, 2);
      check_cnt(4, 19, 2);
      check_cnt(0, 75, 2);
      wr_reg(OFS_PWR, 8'h03);
      settle();
      check({osc_enable, pll_enable}, 8'h00);
      rd_check(OFS_STATUS, 8'h0C);
      meas(200);
      check_cnt(5, 0, 0);
      wr_reg(OFS_PWR, 8'h00);
      settle();
      check({osc_enable, pll_enable}, 8'h03);
      // Clock output from the sys tick, plain and halved
      wr_reg(OFS_MODE_CTRL, 8'h02);
      wr_reg(OFS_CLK_OUT, 8'h00);
      meas(W);
      check_cnt(6, 15, 1);
      wr_reg(OFS_MODE_CTRL, 8'h06);
      meas(W);
      check_cnt(6, 300, 40);
      // Other output sources, plain: live oscillator tick, then the 25 MHz group
      wr_reg(OFS_MODE_CTRL, 8'h02);
      wr_reg(OFS_CLK_OUT, 8'h03);
      rd_check(OFS_CLK_OUT, 8'h03);
      meas(W);
      check_cnt(6, 30, 1);
      wr_reg(OFS_CLK_OUT, 8'h01);
      meas(W);
      check_cnt(6, 5, 1);
      // Second reset in mid-run must restore active mode on the on-chip source
      wr_reg(OFS_PWR, 8'h05);
      rd_check(OFS_PWR, 8'h05);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd_check(OFS_PWR, 8'h00);
      rd_check(OFS_CLK_OUT, 8'h00);
      rd_check(OFS_STATUS, 8'h30);
      check(osc_source_sel, 1'b0);
      summarize();
   end
endmodule : tb
